// ### hw/sds_pkg.sv
// Package: register map, field layout and constants of the microstep sequencer
`default_nettype none
package sds_pkg;

  // ==========================================================================
  // Register map (byte offsets)
  localparam logic [7:0] SDS_ADDR_CONFIG = 8'h00;
  localparam logic [7:0] SDS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SDS_ADDR_POS    = 8'h08;
  localparam logic [7:0] SDS_ADDR_COIL   = 8'h0C;

  // ==========================================================================
  // Field positions
  localparam int SDS_CFG_RES_LSB = 0;
  localparam int SDS_CFG_RES_W   = 4;
  localparam int SDS_CFG_IDX_BIT = 4;
  localparam int SDS_ST_STST_BIT = 0;
  localparam int SDS_ST_STBY_BIT = 1;
  localparam int SDS_ST_BUSY_BIT = 2;
  localparam int SDS_COIL_B_LSB  = 16;

  // ==========================================================================
  // Resolution codes: step width is 2**code, 0 = finest, 8 = full step
  localparam logic [3:0] SDS_RES_MAX = 4'h8;
  localparam logic [3:0] SDS_RES_RST = 4'h4;
  localparam logic       SDS_IDX_RST = 1'b0;

  // ==========================================================================
  // Table and position
  localparam int         SDS_PTR_W     = 10;
  localparam int         SDS_TABLE_QTR = 256;
  localparam logic [9:0] SDS_PTR_RST   = 10'((10'h001 << SDS_RES_RST) >> 1);
  localparam longint     SDS_SINE_AMP  = 64'sh0FF;
  localparam longint     SDS_PI_Q16    = 64'sh3243F;

  // ==========================================================================
  // Timing: standstill limit on the step period, in system clocks
  localparam int unsigned SDS_STST_LIMIT_CLKS = 32'h0010_0000;

  // Quarter-wave sine at elaboration, Taylor series in Q16
  function automatic int sds_sine(input int idx);
    longint x;
    longint x2;
    longint x3;
    longint x5;
    longint x7;
    longint s;
    x  = (longint'(idx) * SDS_PI_Q16) / longint'(2 * SDS_TABLE_QTR);
    x2 = (x * x) >>> 16;
    x3 = (x2 * x) >>> 16;
    x5 = (x3 * x2) >>> 16;
    x7 = (x5 * x2) >>> 16;
    s  = x - x3 / 64'sh6 + x5 / 64'sh78 - x7 / 64'sh13B0;
    return int'((s * SDS_SINE_AMP + 64'sh8000) >>> 16);
  endfunction : sds_sine

endpackage : sds_pkg
`default_nettype wire

// ### hw/sds_sequencer.sv
// Step/direction microstep sequencer with interpolator and AHB-Lite registers
//
// Function
// RULE1: Only rising step edges advance the sequencer.
// RULE2: Step and direction are synchronised before edge detection.
// RULE3: 1024-entry sine table spans one electrical period of four full steps.
// RULE4: Step edge adds width when direction low, subtracts when high.
// RULE5: Step width 1 at finest, doubling per setting, 256 at full step.
// RULE6: Resolution change any time; snap to nearest valid position.
// RULE7: Full step cycles 128, 384, 640, 896 moving 256 per step.
// RULE8: Half step first position 64, moving 128 per step.
// RULE9: Quarter step first position 32, moving 64 per step.
// RULE10: Coarse positions offset by half a width; never zero or peak.
// RULE11: Full-step positions give 0.71 amplitude on both coils.
// RULE12: Each step issues unit microsteps totalling the step width.
// RULE13: Microstep interval is previous step period divided equally.
// RULE14: Period above the interval limit is a standstill event.
// RULE15: Standstill flag set on event, cleared by next step edge.
// RULE16: Standstill requests standby current only if power-down select enabled.
// RULE17: New rate adopted after one full period measured at it.
// RULE18: New step edge abandons remaining microsteps of prior step.
// RULE19: Index active at pointer zero, coil B rising zero crossing.
// RULE20: Controller should supply a jitter-free step frequency.
// RULE21: Position count wraps 1023 to 0 and back.
// RULE22: In index-step mode the index output toggles every step.
// RULE23: Pointer is ten bits, modulo 1024, reset to a valid position.
// RULE24: Resolution is a power-of-two width, applied without losing position.
`timescale 1ns/100ps
`default_nettype none

module sds_sequencer
  import sds_pkg::*;
#(
  parameter int unsigned STST_LIMIT = SDS_STST_LIMIT_CLKS
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_arst_n,
  // AHB-Lite slave
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  output logic [31:0]             o_hrdata,
  // Step, direction and power-down select inputs
  input  wire logic               i_step,
  input  wire logic               i_dir,
  input  wire logic               i_power_down_select,
  // Motor side
  output logic                    o_index,
  output logic                    o_standby_req,
  output logic signed [8:0]       o_coil_a,
  output logic signed [8:0]       o_coil_b
);

  localparam int PER_W = $clog2(STST_LIMIT + 1);

  if (STST_LIMIT < 2 || STST_LIMIT > SDS_STST_LIMIT_CLKS) begin : g_bad_limit
    $error("STST_LIMIT out of range");
  end

  // ==========================================================================
  // Declarations
  logic                 step_s1_r;
  logic                 step_s2_r;
  logic                 step_s3_r;
  logic                 dir_s1_r;
  logic                 dir_s2_r;
  logic                 step_edge;
  logic                 bus_acc;
  logic                 wr_pend_r;
  logic [7:0]           wr_addr_r;
  logic [31:0]          rd_mux;
  logic [3:0]           code_r;
  logic                 idx_step_r;
  logic [3:0]           new_code;
  logic [3:0]           code_eff;
  logic                 cfg_wr;
  logic                 res_chg;
  logic [9:0]           w_eff;
  logic [9:0]           width_cur;
  logic [9:0]           snap;
  logic [9:0]           base;
  logic [9:0]           target_r;
  logic [9:0]           ptr_r;
  logic [8:0]           rem_r;
  logic                 mdir_r;
  logic [PER_W-1:0]     per_cnt_r;
  logic [PER_W-1:0]     period_r;
  logic [PER_W-1:0]     interval;
  logic [PER_W-1:0]     reload;
  logic [PER_W-1:0]     tmr_r;
  logic                 stst_set;
  logic                 stst_r;
  logic [7:0]           sine_lut [0:SDS_TABLE_QTR];
  logic [9:0]           ph_a;
  logic [8:0]           idx_a;
  logic [8:0]           idx_b;
  logic signed [8:0]    coil_a_nxt;
  logic signed [8:0]    coil_b_nxt;

  // ==========================================================================
  // Input synchronisers and edge detect
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      step_s1_r <= 1'b0;
      step_s2_r <= 1'b0;
      step_s3_r <= 1'b0;
      dir_s1_r  <= 1'b0;
      dir_s2_r  <= 1'b0;
    end else begin
      step_s1_r <= i_step; // RULE2
      step_s2_r <= step_s1_r;
      step_s3_r <= step_s2_r;
      dir_s1_r  <= i_dir; // RULE2
      dir_s2_r  <= dir_s1_r;
    end
  end

  assign step_edge = step_s2_r & ~step_s3_r; // RULE1

  // ==========================================================================
  // AHB-Lite slave, zero wait states, OKAY only
  assign bus_acc = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_haddr[7:0])
      SDS_ADDR_CONFIG: begin
        rd_mux[SDS_CFG_RES_LSB +: SDS_CFG_RES_W] = code_r;
        rd_mux[SDS_CFG_IDX_BIT]                  = idx_step_r;
      end
      SDS_ADDR_STATUS: begin
        rd_mux[SDS_ST_STST_BIT] = stst_r;
        rd_mux[SDS_ST_STBY_BIT] = o_standby_req;
        rd_mux[SDS_ST_BUSY_BIT] = (rem_r != 9'h000);
      end
      SDS_ADDR_POS: begin
        rd_mux[SDS_PTR_W-1:0] = ptr_r; // RULE21
      end
      SDS_ADDR_COIL: begin
        rd_mux[8:0]                   = o_coil_a;
        rd_mux[SDS_COIL_B_LSB +: 9]   = o_coil_b;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_r   <= bus_acc && i_hwrite;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (bus_acc) begin
        wr_addr_r <= i_haddr[7:0];
        o_hrdata  <= i_hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================================
  // Resolution control and snapping
  assign new_code  = (i_hwdata[SDS_CFG_RES_LSB +: SDS_CFG_RES_W] > SDS_RES_MAX)
                   ? SDS_RES_MAX : i_hwdata[SDS_CFG_RES_LSB +: SDS_CFG_RES_W];
  assign cfg_wr    = wr_pend_r && (wr_addr_r == SDS_ADDR_CONFIG);
  assign res_chg   = cfg_wr && (new_code != code_r);
  assign code_eff  = cfg_wr ? new_code : code_r;
  assign w_eff     = 10'h001 << code_eff; // RULE5 RULE24
  assign width_cur = 10'h001 << code_r;
  // Nearest position offset by half a width
  assign snap      = (target_r & ~(w_eff - 10'h001)) | (w_eff >> 1); // RULE6 RULE10
  assign base      = res_chg ? snap : target_r;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code_r     <= SDS_RES_RST;
      idx_step_r <= SDS_IDX_RST;
    end else if (cfg_wr) begin
      code_r     <= new_code; // RULE24
      idx_step_r <= i_hwdata[SDS_CFG_IDX_BIT];
    end
  end

  // ==========================================================================
  // Step-resolution target, modulo 1024
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      target_r <= SDS_PTR_RST; // RULE23
    end else if (step_edge) begin
      target_r <= dir_s2_r ? base - w_eff : base + w_eff; // RULE4 RULE7 RULE8 RULE9
    end else begin
      target_r <= base; // RULE6
    end
  end

  // ==========================================================================
  // Period measurement and standstill
  assign stst_set = (per_cnt_r == PER_W'(STST_LIMIT - 1));

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      per_cnt_r <= '0;
      period_r  <= '0;
    end else if (step_edge) begin
      per_cnt_r <= '0;
      period_r  <= stst_r ? '0 : per_cnt_r + 1'b1; // RULE13 RULE17
    end else if (per_cnt_r != PER_W'(STST_LIMIT)) begin
      per_cnt_r <= per_cnt_r + 1'b1;
    end
  end

  // Set wins over the clearing step edge
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stst_r <= 1'b0;
    end else if (stst_set) begin
      stst_r <= 1'b1; // RULE14
    end else if (step_edge) begin
      stst_r <= 1'b0; // RULE15
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_standby_req <= 1'b0;
    end else begin
      o_standby_req <= stst_r && i_power_down_select; // RULE16
    end
  end

  // ==========================================================================
  // Interpolator: unit microsteps spaced by period / width
  assign interval = period_r >> code_r; // RULE13
  assign reload   = (interval == '0) ? '0 : interval - 1'b1;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_r  <= SDS_PTR_RST; // RULE23
      rem_r  <= 9'h000;
      tmr_r  <= '0;
      mdir_r <= 1'b0;
    end else if (step_edge) begin
      ptr_r  <= base; // RULE18
      rem_r  <= w_eff[8:0]; // RULE12
      tmr_r  <= '0;
      mdir_r <= dir_s2_r;
    end else if (res_chg) begin
      ptr_r <= base; // RULE6
      rem_r <= 9'h000;
    end else if (rem_r != 9'h000) begin
      if (tmr_r == '0) begin
        ptr_r <= mdir_r ? ptr_r - 10'h001 : ptr_r + 10'h001; // RULE12 RULE21
        rem_r <= rem_r - 9'h001;
        tmr_r <= reload; // RULE13
      end else begin
        tmr_r <= tmr_r - 1'b1;
      end
    end
  end

  // ==========================================================================
  // Sine table and coil vectors (A = cosine, B = sine)
  for (genvar g = 0; g <= SDS_TABLE_QTR; g++) begin : g_lut
    assign sine_lut[g] = 8'(sds_sine(g)); // RULE3
  end

  always_comb begin
    ph_a  = ptr_r + 10'h100;
    idx_a = ph_a[8] ? 9'h100 - {1'b0, ph_a[7:0]} : {1'b0, ph_a[7:0]};
    idx_b = ptr_r[8] ? 9'h100 - {1'b0, ptr_r[7:0]} : {1'b0, ptr_r[7:0]};
    coil_a_nxt = $signed({1'b0, sine_lut[idx_a]});
    coil_b_nxt = $signed({1'b0, sine_lut[idx_b]});
    coil_a_nxt = ph_a[9] ? -coil_a_nxt : coil_a_nxt; // RULE11
    coil_b_nxt = ptr_r[9] ? -coil_b_nxt : coil_b_nxt;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_coil_a <= 9'sh000;
      o_coil_b <= 9'sh000;
    end else begin
      o_coil_a <= coil_a_nxt;
      o_coil_b <= coil_b_nxt;
    end
  end

  // ==========================================================================
  // Index output
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_index <= 1'b0;
    end else if (idx_step_r) begin
      o_index <= step_edge ? ~o_index : o_index; // RULE22
    end else begin
      o_index <= (ptr_r == 10'h000); // RULE19
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_step_sync_edge: assert property (step_edge |-> $past(i_step, 2) && !$past(i_step, 3)) // RULE1 RULE2
    else $error("step edge without synchronised rise");
  a_target_move: assert property (step_edge && !cfg_wr |=> target_r == ($past(dir_s2_r) // RULE4
    ? $past(target_r) - $past(width_cur) : $past(target_r) + $past(width_cur)))
    else $error("target did not move by step width");
  a_width_pow2: assert property ($onehot(width_cur) && code_r <= SDS_RES_MAX) // RULE5
    else $error("step width not a power of two");
  a_pos_valid: assert property ((target_r & (width_cur - 10'h001)) == (width_cur >> 1)) // RULE10
    else $error("target not on a valid position");
  a_full_step_pos: assert property (code_r == SDS_RES_MAX |-> target_r[7:0] == 8'h80) // RULE7
    else $error("full step off 128 + 256k");
  a_snap_lands: assert property (res_chg && !step_edge |=> ptr_r == target_r && rem_r == 9'h000) // RULE6
    else $error("resolution change did not snap pointer");
  a_settled: assert property (rem_r == 9'h000 |-> ptr_r == target_r) // RULE12
    else $error("microsteps do not total step width");
  a_unit_micro: assert property (ptr_r != $past(ptr_r) && !$past(step_edge) && !$past(res_chg) // RULE12 RULE21
    |-> (ptr_r - $past(ptr_r) == 10'h001) || ($past(ptr_r) - ptr_r == 10'h001))
    else $error("microstep not a unit move");
  a_abandon_rest: assert property (step_edge && !cfg_wr // RULE18
    |=> ptr_r == $past(target_r) && rem_r == $past(width_cur[8:0]))
    else $error("pending microsteps not abandoned");
  a_period_meas: assert property (step_edge && !stst_r // RULE13 RULE17
    |=> period_r == PER_W'($past(per_cnt_r) + 1'b1))
    else $error("step period not measured");
  a_stst_set: assert property (stst_set |=> stst_r) // RULE14
    else $error("standstill not flagged at limit");
  a_stst_clear: assert property (step_edge && !stst_set |=> !stst_r ##1 !stst_r) // RULE15
    else $error("standstill not cleared by step");
  a_standby_req: assert property (1'b1 |=> o_standby_req == $past(stst_r && i_power_down_select)) // RULE16
    else $error("standby request mismatch");
  a_coil_full: assert property ($past(ptr_r) == 10'h080 |-> o_coil_a == o_coil_b // RULE11
    && o_coil_a >= 9'sh0B3 && o_coil_a <= 9'sh0B5)
    else $error("full-step vector not 0.71 amplitude");
  a_index_zero: assert property (!idx_step_r && !$past(idx_step_r) // RULE19
    |-> o_index == ($past(ptr_r) == 10'h000)
      && (!o_index || (o_coil_b == 9'sh000 && o_coil_a == 9'sh0FF)))
    else $error("index not at coil B zero crossing");
  a_index_toggle: assert property (idx_step_r && step_edge |=> o_index != $past(o_index)) // RULE22
    else $error("index did not toggle on step");

  c_standstill_step: cover property (stst_r && step_edge);
  c_abandon: cover property (step_edge && rem_r != 9'h000);
  c_full_step: cover property (code_r == SDS_RES_MAX && step_edge);
  c_wrap: cover property ($past(ptr_r) == 10'h3FF && ptr_r == 10'h000);

endmodule : sds_sequencer

`default_nettype wire

// ### dv/sds_step_src.sv
// Step and direction source standing in for the motion controller
`timescale 1ns/100ps
`default_nettype none

module sds_step_src (
  // Clock
  input  wire logic i_sys_clk,
  // Step and direction
  output logic      o_step,
  output logic      o_dir
);
  initial begin
    o_step = 1'b0;
    o_dir  = 1'b0;
  end

  // ==========================================================================
  // One pulse: dir 3 clocks ahead, high 3 clocks, rise-to-rise = period
  task automatic pulse(input logic d, input int period);
    o_dir <= d;
    repeat (3) @(posedge i_sys_clk);
    o_step <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    o_step <= 1'b0;
    repeat (period - 6) @(posedge i_sys_clk);
  endtask : pulse
endmodule : sds_step_src
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the microstep sequencer
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import sds_pkg::*;
  // ==========================================================================
  // Signals
  logic              clk;
  logic              arst_n;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hready;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              step;
  logic              dir;
  logic              pds;
  logic              index;
  logic              standby;
  logic signed [8:0] coil_a;
  logic signed [8:0] coil_b;
  logic [31:0]       r;
  logic              idx0;
  int                mismatches;
  int                num_checks;

  sds_sequencer #(.STST_LIMIT(64)) DUT (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_step(step), .i_dir(dir), .i_power_down_select(pds), .o_index(index),
    .o_standby_req(standby), .o_coil_a(coil_a), .o_coil_b(coil_b)
  );

  sds_step_src SRC (.i_sys_clk(clk), .o_step(step), .o_dir(dir));

  // ==========================================================================
  // Tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= is_wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask : rchk

  // Poll until no microsteps are pending
  task automatic wait_idle;
    logic [31:0] x;
    do bus(1'b0, SDS_ADDR_STATUS, 32'h0, x); while (x[SDS_ST_BUSY_BIT] !== 1'b0);
  endtask : wait_idle

  task automatic stp(input logic d, input int n, input int period);
    repeat (n) SRC.pulse(d, period);
    wait_idle();
  endtask : stp

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    mismatches = 0;
    num_checks = 0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pds = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk(SDS_ADDR_CONFIG, 32'h4);
    rchk(SDS_ADDR_POS, 32'h8);
    wr(SDS_ADDR_POS, 32'h3FF);
    wr(8'h10, 32'hFFFF_FFFF);
    rchk(SDS_ADDR_POS, 32'h8);
    rchk(8'h10, 32'h0);
    stp(1'b0, 1, 20);
    rchk(SDS_ADDR_POS, 32'h18);
    stp(1'b1, 1, 20);
    rchk(SDS_ADDR_POS, 32'h8);
    // Interpolated microsteps at period/16, then an early edge
    SRC.pulse(1'b0, 60);
    SRC.pulse(1'b0, 60);
    SRC.pulse(1'b0, 8);
    repeat (10) @(posedge clk);
    bus(1'b0, SDS_ADDR_POS, 32'h0, r);
    chk({31'h0, (r >= 41 && r <= 49)}, 32'h1);
    stp(1'b0, 1, 8);
    rchk(SDS_ADDR_POS, 32'h48);
    // Full step: clamp, snap, equal coils, wrap
    wr(SDS_ADDR_CONFIG, 32'hF);
    rchk(SDS_ADDR_CONFIG, 32'h8);
    rchk(SDS_ADDR_POS, 32'h80);
    repeat (3) @(posedge clk);
    chk({23'h0, coil_a}, {23'h0, coil_b});
    chk({31'h0, (coil_a >= 178 && coil_a <= 183)}, 32'h1);
    for (int i = 1; i <= 4; i++) begin
      stp(1'b0, 1, 20);
      rchk(SDS_ADDR_POS, 32'((128 + 256 * i) % 1024));
      if (i == 2) begin
        chk({31'h0, (coil_a == coil_b && coil_a >= -183 && coil_a <= -178)}, 32'h1);
      end
    end
    stp(1'b1, 1, 20);
    rchk(SDS_ADDR_POS, 32'd896);
    wr(SDS_ADDR_CONFIG, 32'h7);
    rchk(SDS_ADDR_POS, 32'd960);
    stp(1'b0, 1, 20);
    rchk(SDS_ADDR_POS, 32'd64);
    wr(SDS_ADDR_CONFIG, 32'h6);
    rchk(SDS_ADDR_POS, 32'd96);
    stp(1'b1, 1, 20);
    rchk(SDS_ADDR_POS, 32'd32);
    // Finest resolution down to the index point
    wr(SDS_ADDR_CONFIG, 32'h0);
    stp(1'b1, 32, 8);
    rchk(SDS_ADDR_POS, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, index}, 32'h1);
    chk({23'h0, coil_b}, 32'h0);
    stp(1'b1, 1, 8);
    rchk(SDS_ADDR_POS, 32'd1023);
    chk({31'h0, index}, 32'h0);
    // Index toggles per step
    wr(SDS_ADDR_CONFIG, 32'h10);
    idx0 = index;
    stp(1'b0, 1, 8);
    chk({31'h0, index}, {31'h0, ~idx0});
    stp(1'b0, 1, 8);
    chk({31'h0, index}, {31'h0, idx0});
    // Standstill and standby request
    repeat (100) @(posedge clk);
    rchk(SDS_ADDR_STATUS, 32'h1);
    chk({31'h0, standby}, 32'h0);
    pds <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(SDS_ADDR_STATUS, 32'h3);
    chk({31'h0, standby}, 32'h1);
    SRC.pulse(1'b0, 8);
    bus(1'b0, SDS_ADDR_STATUS, 32'h0, r);
    chk({31'h0, r[SDS_ST_STST_BIT]}, 32'h0);
    chk({31'h0, standby}, 32'h0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
